// ### rtl/lram_host_regs.v
// Overview of operation
// - three access modes: normal, quick, burst
// - offsets 00h to 2Ch use normal handshake, except burst beats, which take the quick wait
// - quick reads at 30,34,3C,40,44,48,C0
// - quick writes at 30h and 80h-9Ch
// - quick equals normal, only earlier acknowledge
// - burst writes push queue at six locations
// - burst reads at C0h pop receive words
// - 32-bit data, 8-bit address, bit 0 MSB
// - cycle-start request, cycle-acknowledge answer frame transfers
`timescale 1ns/10ps
`include "lram_map.vh"
module lram_host_regs #(
  parameter [31:0] ID_WORD = 32'h0001_0002 // arbitrary identity value
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // host bus pins (asynchronous to clk)
  input wire chip_select_n,
  input wire write_n,
  input wire cycle_start_n,
  input wire burst_n,
  input wire [0:7] host_location_lines,
  input wire [0:31] host_data_in,
  output reg [0:31] host_data_out,
  output reg host_data_oe,
  output reg transfer_acknowledge_n,
  // link-side status inputs (same clock)
  input wire [31:0] event_in,
  input wire [11:0] async_tx_queue_space,
  input wire [31:0] iso_tx_queue_status,
  input wire [31:0] general_rx_queue_status,
  input wire [31:0] ack_queue_word,
  input wire [31:0] general_rx_queue_data,
  // queue strobes
  output reg tx_push,
  output reg [7:0] tx_push_loc,
  output reg [31:0] tx_push_data,
  output reg rx_pop,
  // control outputs
  output reg [31:0] link_control_out,
  output reg event_pending
);

  // handshake states
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_ACK = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops each
  reg [3:0] ctl_s1_reg, ctl_s2_reg; // cs, wr, start, burst
  reg [7:0] loc_s1_reg, loc_s2_reg;
  reg [31:0] dat_s1_reg, dat_s2_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_s1_reg <= 4'hF;
      ctl_s2_reg <= 4'hF;
      loc_s1_reg <= 8'h00;
      loc_s2_reg <= 8'h00;
      dat_s1_reg <= 32'h0000_0000;
      dat_s2_reg <= 32'h0000_0000;
    end else begin
      ctl_s1_reg <= {chip_select_n, write_n, cycle_start_n, burst_n};
      ctl_s2_reg <= ctl_s1_reg;
      // bit 0 is the msb, so vector order maps directly
      loc_s1_reg <= host_location_lines;
      loc_s2_reg <= loc_s1_reg;
      dat_s1_reg <= host_data_in;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  wire cs_act = ~ctl_s2_reg[3]; // chip selected
  wire rd_req = ctl_s2_reg[2]; // high selects read
  wire start_act = ~ctl_s2_reg[1]; // cycle start held
  wire burst_act = ~ctl_s2_reg[0]; // burst transfer

  ////////////////////////////////////////////////////////////////////////
  // location decode
  reg quick_rd, quick_wr, burst_wr, stored_loc;

  // classify the current location by allowed modes
  always @* begin
    quick_rd = 1'b0;
    quick_wr = 1'b0;
    burst_wr = 1'b0;
    stored_loc = 1'b0;
    case (loc_s2_reg)
      `LRAM_OFF_ATQ_STATUS, `LRAM_OFF_ITQ_STATUS, `LRAM_OFF_GRQ_STATUS,
      `LRAM_OFF_HOST_CTRL, `LRAM_OFF_MUX_CTRL, `LRAM_OFF_ACK_QUEUE,
      `LRAM_OFF_RXQ_READ: quick_rd = 1'b1;
      default: quick_rd = 1'b0;
    endcase
    quick_wr = (loc_s2_reg == `LRAM_OFF_ATQ_STATUS) ||
               ((loc_s2_reg >= `LRAM_OFF_TXQ_FIRST) && (loc_s2_reg <= `LRAM_OFF_TXQ_LAST) &&
                (loc_s2_reg[1:0] == 2'b00));
    case (loc_s2_reg)
      `LRAM_OFF_BURST_A, `LRAM_OFF_BURST_B, `LRAM_OFF_BURST_C,
      `LRAM_OFF_BURST_D, `LRAM_OFF_BURST_E, `LRAM_OFF_BURST_F: burst_wr = 1'b1;
      default: burst_wr = 1'b0;
    endcase
    // writable words held in the store; reserved ones excluded
    case (loc_s2_reg)
      `LRAM_OFF_NODE_ADDR, `LRAM_OFF_LINK_CTRL, `LRAM_OFF_EVENT_MASK,
      `LRAM_OFF_CYCLE_TIMER, `LRAM_OFF_ISO_CHAN, `LRAM_OFF_QUEUE_SIZE,
      `LRAM_OFF_DIAG, `LRAM_OFF_PHY_PORT, `LRAM_OFF_ATQ_STATUS,
      `LRAM_OFF_HOST_CTRL, `LRAM_OFF_MUX_CTRL: stored_loc = 1'b1;
      default: stored_loc = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // register store
  reg st_wr_reg; // store write strobe
  reg [4:0] st_idx_reg; // store write index
  reg [31:0] st_wdata_reg; // store write data
  wire [31:0] st_rdata;

  lram_regfile #(
    .AW(5),
    .DW(32)
  ) u_store (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(st_wr_reg),
    .wr_idx(st_idx_reg),
    .wr_data(st_wdata_reg),
    .rd_idx(loc_s2_reg[6:2]),
    .rd_data(st_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // handshake state machine
  reg [2:0] state_reg;
  reg [3:0] cnt_reg; // cycles left before acknowledge
  reg [31:0] event_flags_reg; // sticky link events
  reg [31:0] event_mask_reg; // shadow of the mask word
  reg flag_clr_reg; // write-one clear pulse for flags
  reg [31:0] flag_clr_data_reg;
  reg [31:0] rd_word;
  localparam [7:0] OFF_MASK = `LRAM_OFF_EVENT_MASK; // mask word offset
  localparam [7:0] OFF_CTRL = `LRAM_OFF_LINK_CTRL; // control word offset

  // read data selection, reserved locations give zero
  always @* begin
    rd_word = 32'h0000_0000;
    case (loc_s2_reg)
      `LRAM_OFF_VERSION: rd_word = ID_WORD;
      `LRAM_OFF_EVENT_FLAGS: rd_word = event_flags_reg;
      `LRAM_OFF_ATQ_STATUS: rd_word = {st_rdata[31:`LRAM_ATQ_SPACE_W], async_tx_queue_space};
      `LRAM_OFF_ITQ_STATUS: rd_word = iso_tx_queue_status;
      `LRAM_OFF_GRQ_STATUS: rd_word = general_rx_queue_status;
      `LRAM_OFF_ACK_QUEUE: rd_word = ack_queue_word;
      `LRAM_OFF_RXQ_READ: rd_word = general_rx_queue_data;
      default: rd_word = stored_loc ? st_rdata : 32'h0000_0000;
    endcase
  end

  // request, wait, acknowledge, release
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      transfer_acknowledge_n <= 1'b1;
      host_data_out <= 32'h0000_0000;
      host_data_oe <= 1'b0;
      tx_push <= 1'b0;
      tx_push_loc <= 8'h00;
      tx_push_data <= 32'h0000_0000;
      rx_pop <= 1'b0;
      st_wr_reg <= 1'b0;
      st_idx_reg <= 5'h00;
      st_wdata_reg <= 32'h0000_0000;
      flag_clr_reg <= 1'b0;
      flag_clr_data_reg <= 32'h0000_0000;
    end else begin
      tx_push <= 1'b0;
      rx_pop <= 1'b0;
      st_wr_reg <= 1'b0;
      flag_clr_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // chip select plus cycle start opens an access
          if (cs_act && start_act) begin
            state_reg <= ST_WAIT;
            // quick and burst beats both take the shorter wait
            if ((rd_req && quick_rd) || (!rd_req && quick_wr) || burst_act) begin
              cnt_reg <= `LRAM_ACK_QUICK_CYC;
            end else begin
              cnt_reg <= `LRAM_ACK_NORMAL_CYC;
            end
          end
        end
        ST_WAIT: begin
          if (cnt_reg > 4'h1) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            state_reg <= ST_ACK;
            transfer_acknowledge_n <= 1'b0;
            if (rd_req) begin
              host_data_out <= rd_word;
              host_data_oe <= 1'b1;
              // each receive read beat pops one word
              if (loc_s2_reg == `LRAM_OFF_RXQ_READ && (!burst_act || rd_req)) begin
                rx_pop <= 1'b1;
              end
            end else if (burst_act) begin
              // burst beat pushes only at burst locations
              if (burst_wr) begin
                tx_push <= 1'b1;
                tx_push_loc <= loc_s2_reg;
                tx_push_data <= dat_s2_reg;
              end
            end else if (quick_wr && loc_s2_reg != `LRAM_OFF_ATQ_STATUS) begin
              tx_push <= 1'b1;
              tx_push_loc <= loc_s2_reg;
              tx_push_data <= dat_s2_reg;
            end else if (stored_loc) begin
              st_wr_reg <= 1'b1;
              st_idx_reg <= loc_s2_reg[6:2];
              st_wdata_reg <= dat_s2_reg;
            end else if (loc_s2_reg == `LRAM_OFF_EVENT_FLAGS) begin
              flag_clr_reg <= 1'b1;
              flag_clr_data_reg <= dat_s2_reg;
            end
          end
        end
        ST_ACK: begin
          // release once the host drops its request
          if (!start_act) begin
            state_reg <= ST_IDLE;
            transfer_acknowledge_n <= 1'b1;
            host_data_oe <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          transfer_acknowledge_n <= 1'b1;
          host_data_oe <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags, control shadows and pending output
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      event_flags_reg <= `LRAM_RST_WORD;
      event_mask_reg <= `LRAM_RST_WORD;
      link_control_out <= `LRAM_RST_WORD;
      event_pending <= 1'b0;
    end else begin
      // new events win over a simultaneous clear
      if (flag_clr_reg) begin
        event_flags_reg <= (event_flags_reg & ~flag_clr_data_reg) | event_in;
      end else begin
        event_flags_reg <= event_flags_reg | event_in;
      end
      // shadows follow store writes
      if (st_wr_reg && st_idx_reg == OFF_MASK[6:2]) begin
        event_mask_reg <= st_wdata_reg;
      end
      if (st_wr_reg && st_idx_reg == OFF_CTRL[6:2]) begin
        link_control_out <= st_wdata_reg;
      end
      event_pending <= |(event_flags_reg & event_mask_reg);
    end
  end

endmodule

// ### rtl/lram_map.vh
`ifndef LRAM_MAP_VH
`define LRAM_MAP_VH
// register offsets (byte addresses on the host location lines)
`define LRAM_OFF_VERSION 8'h00
`define LRAM_OFF_NODE_ADDR 8'h04
`define LRAM_OFF_LINK_CTRL 8'h08
`define LRAM_OFF_EVENT_FLAGS 8'h0C
`define LRAM_OFF_EVENT_MASK 8'h10
`define LRAM_OFF_CYCLE_TIMER 8'h14
`define LRAM_OFF_ISO_CHAN 8'h18
`define LRAM_OFF_QUEUE_SIZE 8'h1C
`define LRAM_OFF_DIAG 8'h20
`define LRAM_OFF_PHY_PORT 8'h24
`define LRAM_OFF_RSVD_28 8'h28
`define LRAM_OFF_RSVD_2C 8'h2C
`define LRAM_OFF_NORMAL_LAST 8'h2C
`define LRAM_OFF_ATQ_STATUS 8'h30
`define LRAM_OFF_ITQ_STATUS 8'h34
`define LRAM_OFF_GRQ_STATUS 8'h3C
`define LRAM_OFF_HOST_CTRL 8'h40
`define LRAM_OFF_MUX_CTRL 8'h44
`define LRAM_OFF_ACK_QUEUE 8'h48
`define LRAM_OFF_TXQ_FIRST 8'h80
`define LRAM_OFF_TXQ_LAST 8'h9C
`define LRAM_OFF_BURST_A 8'h84
`define LRAM_OFF_BURST_B 8'h8C
`define LRAM_OFF_BURST_C 8'h94
`define LRAM_OFF_BURST_D 8'h9C
`define LRAM_OFF_BURST_E 8'hA0
`define LRAM_OFF_BURST_F 8'hB0
`define LRAM_OFF_RXQ_READ 8'hC0
// async tx queue status: low field replaced by live space count
`define LRAM_ATQ_SPACE_LSB 0
`define LRAM_ATQ_SPACE_W 12
// reset values of stored registers
`define LRAM_RST_WORD 32'h0000_0000
// acknowledge latency in clock cycles after the request is seen
`define LRAM_ACK_NORMAL_CYC 4'h6
`define LRAM_ACK_QUICK_CYC 4'h2
`endif

// ### rtl/lram_regfile.v
`timescale 1ns/10ps
// small register store with registered read data
module lram_regfile #(
  parameter AW = 5,
  parameter DW = 32
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_idx,
  input wire [DW-1:0] wr_data,
  // read port
  input wire [AW-1:0] rd_idx,
  output reg [DW-1:0] rd_data
);

  localparam DEPTH = 1 << AW;

  reg [DW-1:0] mem_reg [0:DEPTH-1]; // storage words
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // write and registered read
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {DW{1'b0}};
      end
      rd_data <= {DW{1'b0}};
    end else begin
      if (wr_en) begin
        mem_reg[wr_idx] <= wr_data;
      end
      rd_data <= mem_reg[rd_idx];
    end
  end

endmodule

// ### bench/lram_host_regs_monitor.sv
`timescale 1ns/10ps
// protocol checker on the host bus pins
module lram_host_regs_monitor (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // host request pins
  input wire chip_select_n,
  input wire write_n,
  input wire cycle_start_n,
  input wire [0:7] host_location_lines,
  // device answers
  input wire transfer_acknowledge_n,
  input wire host_data_oe,
  input wire tx_push,
  input wire [7:0] tx_push_loc,
  input wire rx_pop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // request seen and acknowledge given
  sequence s_req; $fell(cycle_start_n) && !chip_select_n; endsequence
  sequence s_ack; $fell(transfer_acknowledge_n); endsequence
  property p_ack_hold; s_ack |-> !transfer_acknowledge_n [*2]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_normal_slow; s_req ##0 (host_location_lines <= 8'h2C) |-> transfer_acknowledge_n [*7]; endproperty
  a_normal_slow: assert property (p_normal_slow) else $error("low range acked fast");
  property p_quick_rd; s_req ##0 (write_n && host_location_lines == 8'hC0) |-> ##[1:7] s_ack; endproperty
  a_quick_rd: assert property (p_quick_rd) else $error("quick read slow");
  property p_quick_wr;
    s_req ##0 (!write_n && host_location_lines >= 8'h80 && host_location_lines <= 8'h9C) |-> ##[1:7] s_ack;
  endproperty
  a_quick_wr: assert property (p_quick_wr) else $error("quick write slow");
  property p_push_ack; tx_push |-> s_ack; endproperty
  a_push_ack: assert property (p_push_ack) else $error("push off ack");
  property p_push_once; tx_push |=> !tx_push; endproperty
  a_push_once: assert property (p_push_once) else $error("push too long");
  property p_push_loc; tx_push |-> !write_n && tx_push_loc == host_location_lines; endproperty
  a_push_loc: assert property (p_push_loc) else $error("push location wrong");
  property p_pop; rx_pop |-> s_ack ##0 (write_n && host_location_lines == 8'hC0); endproperty
  a_pop: assert property (p_pop) else $error("pop without read");
  property p_oe; host_data_oe |-> write_n && !transfer_acknowledge_n; endproperty
  a_oe: assert property (p_oe) else $error("bus driven outside read");
endmodule
bind lram_host_regs lram_host_regs_monitor i_mon (.clk, .rst_b, .chip_select_n, .write_n, .cycle_start_n,
  .host_location_lines, .transfer_acknowledge_n, .host_data_oe, .tx_push, .tx_push_loc, .rx_pop);

// ### bench/lram_host_model.sv
`timescale 1ns/10ps
// host processor on the local bus
module lram_host_model (
  // clock
  input wire clk,
  // request pins
  output logic chip_select_n,
  output logic write_n,
  output logic cycle_start_n,
  output logic burst_n,
  output logic [0:7] host_location_lines,
  output logic [0:31] host_data_in,
  // answer pins
  input wire [0:31] host_data_out,
  input wire transfer_acknowledge_n
);
  initial begin
    {chip_select_n, write_n, cycle_start_n, burst_n} = 4'hF;
    host_location_lines = 8'h00;
    host_data_in = 32'h0000_0000;
  end
  // one four-phase access, timing never relied on
  task automatic xfer(input logic [7:0] a, input logic wr, bst, input logic [31:0] d,
                      output logic [31:0] rd, output int cyc);
    cyc = 0;
    @(negedge clk);
    chip_select_n = 1'b0;
    write_n = !wr;
    burst_n = !bst;
    host_location_lines = a;
    host_data_in = d;
    cycle_start_n = 1'b0;
    // bounded wait for the acknowledge
    do begin
      @(posedge clk);
      cyc++;
    end while (transfer_acknowledge_n !== 1'b0 && cyc < 40);
    rd = host_data_out;
    @(negedge clk);
    cycle_start_n = 1'b1;
    for (int k = 0; k < 20 && transfer_acknowledge_n !== 1'b1; k++) @(posedge clk);
    @(negedge clk);
    // released bus shows the inverse, never a stale value
    {chip_select_n, burst_n} = 2'h3;
    host_data_in = ~host_data_in;
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR at %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  // stimulus values
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] rx_word = 32'h5A00_0000;
  logic [11:0] space = 12'h3A5;
  logic [31:0] ev = 32'h0000_0000;
  localparam logic [31:0] ITQ = 32'h0123_4567;
  localparam logic [31:0] GRQ = 32'h89AB_CDEF;
  localparam logic [31:0] ACKW = 32'hC3C3_0000;
  localparam logic [31:0] ID = 32'h0000_0A5A; // arbitrary identity value
  // nets between host and device
  wire cs_n, wr_n, st_n, bs_n, ack_n, oe, push, pop, pend;
  wire [0:7] loc;
  wire [0:31] din, dout;
  wire [7:0] p_loc;
  wire [31:0] p_dat, lctl;
  int n_errors = 0, checks_done = 0, n_push = 0, n_pop = 0, ticks = 0;
  logic [7:0] last_loc;
  logic [31:0] last_data;
  always #2 clk = ~clk;
  lram_host_regs #(.ID_WORD(ID)) i_lram_host_regs (.clk(clk), .rst_b(rst_b), .chip_select_n(cs_n),
    .write_n(wr_n), .cycle_start_n(st_n), .burst_n(bs_n), .host_location_lines(loc), .host_data_in(din),
    .host_data_out(dout), .host_data_oe(oe), .transfer_acknowledge_n(ack_n), .event_in(ev),
    .async_tx_queue_space(space), .iso_tx_queue_status(ITQ), .general_rx_queue_status(GRQ),
    .ack_queue_word(ACKW), .general_rx_queue_data(rx_word), .tx_push(push), .tx_push_loc(p_loc),
    .tx_push_data(p_dat), .rx_pop(pop), .link_control_out(lctl), .event_pending(pend));
  lram_host_model i_lram_host_model (.clk(clk), .chip_select_n(cs_n), .write_n(wr_n), .cycle_start_n(st_n),
    .burst_n(bs_n), .host_location_lines(loc), .host_data_in(din), .host_data_out(dout),
    .transfer_acknowledge_n(ack_n));
  // record strobes, advance receive word, cut hangs
  always @(negedge clk) begin
    ticks++;
    if (push) begin
      n_push++;
      last_loc = p_loc;
      last_data = p_dat;
    end
    if (pop) begin
      n_pop++;
      rx_word = rx_word + 32'h0000_0001;
    end
    if (ticks == 4000) begin
      n_errors++;
      end_of_test;
    end
  end
  // one access with its checks; q: 0 slow, 1 fast, 2 either
  task automatic acc(input logic [7:0] a, input logic wr, bst, input logic [31:0] d, e, input int q, np);
    logic [31:0] rd;
    int cyc, n0;
    n0 = n_push;
    i_lram_host_model.xfer(a, wr, bst, d, rd, cyc);
    `CHK(int'(cyc < 40), 1)
    `CHK(ack_n, 1'b1)
    if (!wr) `CHK(rd, e)
    if (q < 2) `CHK(int'(cyc <= 8), q)
    `CHK(n_push - n0, np)
    if (np > 0) `CHK({last_loc, last_data}, {a, d})
  endtask
  // sticky event flags, mask to pending, write-one clear
  task t_events;
    acc(8'h10, 1, 0, 32'h0000_0003, 0, 0, 0);
    @(negedge clk) ev = 32'h0000_0011;
    @(negedge clk) ev = 32'h0000_0000;
    @(negedge clk) `CHK(pend, 1'b1)
    acc(8'h0C, 0, 0, 0, 32'h0000_0011, 0, 0);
    acc(8'h0C, 1, 0, 32'h0000_0001, 0, 0, 0);
    acc(8'h0C, 0, 0, 0, 32'h0000_0010, 0, 0);
    `CHK(pend, 1'b0)
    acc(8'h10, 0, 0, 0, 32'h0000_0003, 0, 0);
  endtask
  task t_normal;
    `CHK({ack_n, oe, lctl}, {1'b1, 1'b0, 32'h0000_0000})
    acc(8'h00, 0, 0, 0, ID, 0, 0);
    acc(8'h08, 1, 0, 32'hA5C3_0F96, 0, 0, 0);
    acc(8'h08, 0, 0, 0, 32'hA5C3_0F96, 0, 0);
    `CHK(lctl, 32'hA5C3_0F96)
    acc(8'h00, 1, 0, 32'hFFFF_FFFF, 0, 0, 0);
    acc(8'h00, 0, 0, 0, ID, 0, 0);
    acc(8'h28, 1, 0, 32'hFFFF_FFFF, 0, 0, 0);
    acc(8'h28, 0, 0, 0, 32'h0000_0000, 0, 0);
  endtask
  task t_quick;
    logic [7:0] qa [7];
    logic [31:0] qe [7];
    qa = '{8'h30, 8'h34, 8'h3C, 8'h40, 8'h44, 8'h48, 8'hC0};
    qe = '{{20'h0_0000, space}, ITQ, GRQ, 32'h0000_0000, 32'h0000_0000, ACKW, rx_word};
    for (int k = 0; k < 7; k++) acc(qa[k], 0, 0, 0, qe[k], 1, 0);
    acc(8'h30, 1, 0, 32'hFFFF_FFFF, 0, 1, 0);
    acc(8'h30, 0, 0, 0, {20'hF_FFFF, space}, 1, 0);
    for (int a = 8'h80; a <= 8'h9C; a += 4) acc(a[7:0], 1, 0, {24'hC0_0000, a[7:0]}, 0, 1, 1);
  endtask
  task t_burst;
    logic [7:0] ba [6];
    int p0;
    ba = '{8'h84, 8'h8C, 8'h94, 8'h9C, 8'hA0, 8'hB0};
    for (int k = 0; k < 6; k++) acc(ba[k], 1, 1, {24'hB0B000, ba[k]}, 0, 1, 1);
    acc(8'h40, 1, 1, 32'h1234_5678, 0, 2, 0);
    p0 = n_pop;
    for (int k = 0; k < 3; k++) acc(8'hC0, 0, 1, 0, rx_word, 1, 0);
    `CHK(n_pop - p0, 3)
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_normal;
    t_events;
    t_quick;
    t_burst;
    end_of_test;
  end
endmodule
